// [common/ictm_pkg.sv]
package ictm_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_LINK_CTRL = 8'h08;
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h10;
  localparam logic [7:0] ADDR_CYCLE_TIME = 8'h14;
  localparam logic [11:0] CSR_CYCLE_TIME = 12'h200;
  // ==========================================================
  // field positions as lsb indices (host numbers bit 0 as msb)
  localparam int CTRL_MASTER_BIT = 31 - 20;
  localparam int CTRL_SRC_BIT = 31 - 21;
  localparam int CTRL_RUN_BIT = 31 - 22;
  localparam int EVT_STARTED_BIT = 31 - 22;
  localparam int EVT_DONE_BIT = 31 - 23;
  localparam int EVT_LOST_BIT = 31 - 25;
  localparam int OFFSET_LSB = 0;
  localparam int COUNT_LSB = 12;
  localparam int SECONDS_LSB = 25;
  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] TIME_RST = 32'h0000_0000;
  // ==========================================================
  // counts
  localparam logic [11:0] OFFSET_LAST = 12'hbff;
  localparam logic [12:0] COUNT_LAST = 13'h1f3f;
  localparam int CORE_CLK_KHZ = 40000;
  localparam int OFFSET_CLK_KHZ = 24576;
  localparam logic [16:0] NCO_INC = 17'(OFFSET_CLK_KHZ);
  localparam logic [16:0] NCO_MOD = 17'(CORE_CLK_KHZ);
  localparam logic [1:0] LOST_ROLLS = 2'h2;
endpackage

// [common/ictm_if.sv]
`timescale 1ns/1ps
interface ictm_if;
  logic run;
  logic src_ext;
  logic master;
  logic sync_rise;
  logic host_wr;
  logic [31:0] host_val;
  logic rx_load;
  logic [31:0] rx_val;
  logic [31:0] time_val;
  logic tick;
  logic roll;
  logic rx_start;
  logic tx_sent;
  logic isoch_end;
  logic set_started;
  logic set_lost;
  logic set_done;
  logic tx_req;
  modport tmr(input run, src_ext, sync_rise, host_wr, host_val, rx_load,
    rx_val, output time_val, tick, roll);
  modport mon(input master, tick, roll, rx_start, tx_sent, isoch_end,
    output set_started, set_lost, set_done, tx_req);
  modport top(output run, src_ext, master, sync_rise, host_wr, host_val,
    rx_load, rx_val, rx_start, tx_sent, isoch_end,
    input time_val, tick, roll, set_started, set_lost, set_done, tx_req);
endinterface

// [logic/ictm_cycle_timer.sv]
`timescale 1ns/1ps
module ictm_cycle_timer
  import ictm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  ictm_if.tmr bus
);
  logic [16:0] nco_r;
  logic [17:0] nco_sum;
  logic nco_step;
  logic [11:0] offset;
  logic [12:0] count;
  logic [6:0] secs;
  logic bump;

  assign offset = bus.time_val[COUNT_LSB-1:OFFSET_LSB];
  assign count = bus.time_val[SECONDS_LSB-1:COUNT_LSB];
  assign secs = bus.time_val[31:SECONDS_LSB];
  assign nco_sum = {1'b0, nco_r} + {1'b0, NCO_INC};
  assign nco_step = nco_sum >= {1'b0, NCO_MOD};
  // ==========================================================
  // rate converter: 24.576 MHz steps out of the 40 MHz core clock
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nco_r <= '0;
    end else if (nco_step) begin
      nco_r <= 17'(nco_sum - {1'b0, NCO_MOD});
    end else begin
      nco_r <= nco_sum[16:0];
    end
  end

  assign bus.roll = bus.run && !bus.src_ext && nco_step &&
    offset == OFFSET_LAST;
  assign bump = bus.run && (bus.src_ext ? bus.sync_rise : bus.roll);
  // ==========================================================
  // time register; software write beats packet load beats counting
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bus.time_val <= TIME_RST;
      bus.tick <= 1'b0;
    end else begin
      bus.tick <= bump && !bus.host_wr && !bus.rx_load;
      if (bus.host_wr) begin
        bus.time_val <= bus.host_val;
      end else if (bus.rx_load) begin
        bus.time_val <= bus.rx_val;
      end else if (bump) begin
        bus.time_val[COUNT_LSB-1:OFFSET_LSB] <= '0;
        if (count == COUNT_LAST) begin
          bus.time_val[SECONDS_LSB-1:COUNT_LSB] <= '0;
          bus.time_val[31:SECONDS_LSB] <= 7'(secs + 7'h01);
        end else begin
          bus.time_val[SECONDS_LSB-1:COUNT_LSB] <= 13'(count + 13'h0001);
        end
      end else if (bus.run && !bus.src_ext && nco_step) begin
        bus.time_val[COUNT_LSB-1:OFFSET_LSB] <= 12'(offset + 12'h001);
      end
      // run clear idles the counting branches above; software writes and packet loads still land
    end
  end
endmodule // ictm_cycle_timer

// [logic/ictm_cycle_monitor.sv]
`timescale 1ns/1ps
module ictm_cycle_monitor
  import ictm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  ictm_if.mon bus
);
  logic [1:0] miss_r;
  logic active_r;
  logic started;

  assign started = bus.master ? bus.tx_sent : bus.rx_start;
  assign bus.set_started = started;
  assign bus.set_lost = !bus.master && bus.roll && !bus.rx_start &&
    miss_r == LOST_ROLLS - 2'h1;
  assign bus.set_done = active_r && bus.isoch_end;
  // ==========================================================
  // rollovers seen since the last received cycle start
  always_ff @(posedge core_clk_i) begin
    if (rst_i || bus.master || bus.rx_start) begin
      miss_r <= '0;
    end else if (bus.roll && miss_r != LOST_ROLLS) begin
      miss_r <= 2'(miss_r + 2'h1);
    end
  end

  // done only counts for a cycle that actually started
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      active_r <= 1'b0;
    end else if (started) begin
      active_r <= 1'b1;
    end else if (bus.set_done || bus.set_lost) begin
      active_r <= 1'b0;
    end
  end

  // request held until the transmitter reports it sent
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !bus.master) begin
      bus.tx_req <= 1'b0;
    end else if (bus.tick) begin
      bus.tx_req <= 1'b1;
    end else if (bus.tx_sent) begin
      bus.tx_req <= 1'b0;
    end
  end
endmodule // ictm_cycle_monitor

// [logic/ictm_top.sv]
`timescale 1ns/1ps
module ictm_top
  import ictm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  // host bus, bit 0 is the msb
  input wire logic host_cs_n_i,
  input wire logic host_wr_n_i,
  input wire logic [0:7] host_addr_i,
  input wire logic [0:31] host_data_i,
  output logic [0:31] host_data_o,
  output logic host_ack_n_o,
  // standard register space access from the packet logic
  input wire logic csr_req_i,
  input wire logic csr_wr_i,
  input wire logic [11:0] csr_addr_i,
  input wire logic [31:0] csr_wdata_i,
  output logic [31:0] csr_rdata_o,
  output logic csr_ack_o,
  // external cycle sync pin and tick out
  input wire logic cycle_sync_input_i,
  output logic cycle_tick_output_o,
  // receiver side
  input wire logic rx_cycle_start_i,
  input wire logic [31:0] rx_cycle_time_i,
  // transmitter side
  output logic tx_cycle_start_req_o,
  output logic [31:0] tx_cycle_time_o,
  input wire logic tx_cycle_start_sent_i,
  input wire logic isoch_end_i
);
  typedef enum logic [2:0] {
    HB_IDLE = 3'b001,
    HB_ACCESS = 3'b010,
    HB_HOLD = 3'b100
  } ictm_hb_state_t;

  ictm_if cyc();

  // ==========================================================
  // pin synchronisers
  logic cs_meta_r;
  logic cs_sync_r;
  logic wr_meta_r;
  logic wr_sync_r;
  logic sync_meta_r;
  logic sync_q_r;
  logic sync_prev_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      wr_meta_r <= 1'b1;
      wr_sync_r <= 1'b1;
    end else begin
      cs_meta_r <= host_cs_n_i;
      cs_sync_r <= cs_meta_r;
      wr_meta_r <= host_wr_n_i;
      wr_sync_r <= wr_meta_r;
    end
  end

  // third stage gives the edge detector a settled reference
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync_meta_r <= 1'b0;
      sync_q_r <= 1'b0;
      sync_prev_r <= 1'b0;
    end else begin
      sync_meta_r <= cycle_sync_input_i;
      sync_q_r <= sync_meta_r;
      sync_prev_r <= sync_q_r;
    end
  end

  // ==========================================================
  // host address and data take the same two stages as select
  logic [7:0] addr_meta_r;
  logic [7:0] addr_sync_r;
  logic [31:0] data_meta_r;
  logic [31:0] data_sync_r;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_meta_r <= 8'h00;
      addr_sync_r <= 8'h00;
      data_meta_r <= 32'h0000_0000;
      data_sync_r <= 32'h0000_0000;
    end else begin
      addr_meta_r <= host_addr_i;
      addr_sync_r <= addr_meta_r;
      data_meta_r <= host_data_i;
      data_sync_r <= data_meta_r;
    end
  end

  // ==========================================================
  // registers
  logic [31:0] ctrl_r;
  logic [31:0] flags_r;
  logic [31:0] mask_r;
  logic [31:0] flags_used;
  logic run;
  logic src_ext;
  logic master;

  assign run = ctrl_r[CTRL_RUN_BIT];
  assign src_ext = ctrl_r[CTRL_SRC_BIT];
  assign master = ctrl_r[CTRL_MASTER_BIT];

  // ==========================================================
  // host bus slave
  ictm_hb_state_t hb_state_r;
  ictm_hb_state_t hb_state_nxt;
  logic [7:0] hb_addr;
  logic [31:0] hb_wdata;
  logic hb_go;
  logic hb_wr;
  logic hb_rd;

  // address and data must stay stable while select is low
  assign hb_addr = addr_sync_r;
  assign hb_wdata = data_sync_r;
  assign hb_go = hb_state_r == HB_ACCESS;
  assign hb_wr = hb_go && !wr_sync_r;
  assign hb_rd = hb_go && wr_sync_r;

  // every register write strobe is decoded the same way
  function automatic logic addr_hit(input logic go, input logic [7:0] a,
    input logic [7:0] sel);
    return go && a == sel;
  endfunction

  logic ctrl_wr;
  logic mask_wr;
  logic flags_wr;
  assign ctrl_wr = addr_hit(hb_wr, hb_addr, ADDR_LINK_CTRL);
  assign mask_wr = addr_hit(hb_wr, hb_addr, ADDR_EVENT_MASK);
  assign flags_wr = addr_hit(hb_wr, hb_addr, ADDR_EVENT_FLAGS);

  always_comb begin
    hb_state_nxt = hb_state_r;
    unique case (hb_state_r)
      HB_IDLE: begin
        if (!cs_sync_r) begin
          hb_state_nxt = HB_ACCESS;
        end
      end
      HB_ACCESS: begin
        hb_state_nxt = HB_HOLD;
      end
      HB_HOLD: begin
        if (cs_sync_r) begin
          hb_state_nxt = HB_IDLE;
        end
      end
      default: begin
        hb_state_nxt = HB_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hb_state_r <= HB_IDLE;
    end else begin
      hb_state_r <= hb_state_nxt;
    end
  end

  // acknowledge stays low until the host drops select
  assign host_ack_n_o = hb_state_r != HB_HOLD;

  // unmapped addresses read as zero
  function automatic logic [31:0] read_mux(input logic [7:0] a,
    input logic [31:0] c, input logic [31:0] f, input logic [31:0] m,
    input logic [31:0] t);
    logic [31:0] v;
    v = '0;
    unique case (a)
      ADDR_LINK_CTRL: v = c;
      ADDR_EVENT_FLAGS: v = f;
      ADDR_EVENT_MASK: v = m;
      ADDR_CYCLE_TIME: v = t;
      default: v = '0;
    endcase
    return v;
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      host_data_o <= '0;
    end else if (hb_rd) begin
      host_data_o <= read_mux(hb_addr, ctrl_r, flags_r, mask_r,
        cyc.time_val);
    end
  end

  // ==========================================================
  // control and mask
  logic [31:0] ctrl_wmask;
  assign ctrl_wmask = (32'h1 << CTRL_MASTER_BIT) |
    (32'h1 << CTRL_SRC_BIT) | (32'h1 << CTRL_RUN_BIT);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_wr) begin
      // only the three timer bits are kept; the rest read as zero
      ctrl_r <= hb_wdata & ctrl_wmask;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mask_r <= MASK_RST;
    end else if (mask_wr) begin
      mask_r <= hb_wdata & flags_used;
    end
  end

  // ==========================================================
  // event flags: write one to clear, a new event wins the clear
  logic [31:0] flags_set;
  logic [31:0] flags_clr;

  assign flags_used = (32'h1 << EVT_STARTED_BIT) |
    (32'h1 << EVT_DONE_BIT) | (32'h1 << EVT_LOST_BIT);
  assign flags_set = ({31'h0, cyc.set_started} << EVT_STARTED_BIT) |
    ({31'h0, cyc.set_done} << EVT_DONE_BIT) |
    ({31'h0, cyc.set_lost} << EVT_LOST_BIT);
  assign flags_clr = flags_wr ? hb_wdata : 32'h0;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= ((flags_r & ~flags_clr) | flags_set) &
        flags_used;
    end
  end

  // ==========================================================
  // standard register space port, answered next cycle
  logic csr_hit;
  assign csr_hit = csr_addr_i == CSR_CYCLE_TIME;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      csr_ack_o <= 1'b0;
    end else begin
      csr_ack_o <= csr_req_i;
    end
  end

  // read data holds between reads, like the host side
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      csr_rdata_o <= '0;
    end else if (csr_req_i && !csr_wr_i) begin
      csr_rdata_o <= csr_hit ? cyc.time_val : 32'h0;
    end
  end

  // ==========================================================
  // timer and monitor wiring
  logic host_time_wr;
  logic csr_time_wr;
  assign host_time_wr = addr_hit(hb_wr, hb_addr, ADDR_CYCLE_TIME);
  assign csr_time_wr = csr_req_i && csr_wr_i && csr_hit;

  assign cyc.run = run;
  assign cyc.src_ext = src_ext;
  assign cyc.master = master;
  assign cyc.sync_rise = sync_q_r && !sync_prev_r;
  // host write wins when both ports write together
  assign cyc.host_wr = host_time_wr || csr_time_wr;
  assign cyc.host_val = host_time_wr ? hb_wdata : csr_wdata_i;
  // a master ignores received starts; its own count is the reference
  assign cyc.rx_load = rx_cycle_start_i && !master;
  assign cyc.rx_val = rx_cycle_time_i;
  assign cyc.rx_start = rx_cycle_start_i;
  assign cyc.tx_sent = tx_cycle_start_sent_i;
  assign cyc.isoch_end = isoch_end_i;

  ictm_cycle_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus(cyc.tmr)
  );

  ictm_cycle_monitor u_monitor (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bus(cyc.mon)
  );

  assign cycle_tick_output_o = cyc.tick;
  assign tx_cycle_start_req_o = cyc.tx_req;
  // live value; the transmitter samples it as it sends the start
  assign tx_cycle_time_o = cyc.time_val;
endmodule // ictm_top

// [sim/ictm_top_monitor.sv]
`timescale 1ns/1ps
// ====
// port checker
module ictm_top_monitor
  import ictm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic host_cs_n_i,
  input wire logic host_ack_n_o,
  input wire logic csr_req_i,
  input wire logic csr_ack_o,
  input wire logic rx_cycle_start_i,
  input wire logic cycle_tick_output_o,
  input wire logic tx_cycle_start_req_o,
  input wire logic [31:0] tx_cycle_time_o,
  input wire logic tx_cycle_start_sent_i
);
  logic [11:0] off;
  logic [12:0] cnt;
  logic [6:0] sec;
  assign off = tx_cycle_time_o[11:0];
  assign cnt = tx_cycle_time_o[24:12];
  assign sec = tx_cycle_time_o[31:25];
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ack_wait;
    host_ack_n_o [*2] ##[1:4] !host_ack_n_o;
  endsequence
  // no host, csr or packet load landed this cycle
  sequence s_quiet;
    !$past(rx_cycle_start_i) && !csr_ack_o && host_ack_n_o;
  endsequence
  AST_ACK_LAT: assert property ($fell(host_cs_n_i) |-> s_ack_wait)
    else $error("host ack late");
  AST_ACK_HOLD: assert property (!host_cs_n_i && !host_ack_n_o |=>
    !host_ack_n_o) else $error("host ack dropped early");
  AST_ACK_REL: assert property (host_cs_n_i [*5] |-> host_ack_n_o)
    else $error("host ack stuck low");
  AST_CSR_ACK: assert property (csr_ack_o == $past(csr_req_i))
    else $error("csr ack timing");
  AST_OFF_STEP: assert property (s_quiet ##0 !cycle_tick_output_o |->
    off == $past(off) || off == $past(off) + 12'h001)
    else $error("offset jumped");
  AST_ROLL_TICK: assert property (s_quiet ##0 $past(off) == 12'hbff
    ##0 off == 12'h000 |-> cycle_tick_output_o)
    else $error("rollover without tick");
  AST_TICK_CNT: assert property (cycle_tick_output_o |->
    (cnt == ($past(cnt) == 13'h1f3f ? 13'h0000 : $past(cnt) + 13'h0001))
    && (sec == (cnt == 13'h0000 ? $past(sec) + 7'h01 : $past(sec))))
    else $error("tick without count step");
  AST_REQ_RISE: assert property ($rose(tx_cycle_start_req_o) |->
    $past(cycle_tick_output_o)) else $error("request not on new cycle");
  AST_REQ_DROP: assert property (tx_cycle_start_sent_i |=>
    !tx_cycle_start_req_o) else $error("request held after send");
endmodule // ictm_top_monitor

bind ictm_top ictm_top_monitor u_mon (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .host_cs_n_i(host_cs_n_i), .host_ack_n_o(host_ack_n_o),
  .csr_req_i(csr_req_i), .csr_ack_o(csr_ack_o),
  .rx_cycle_start_i(rx_cycle_start_i),
  .cycle_tick_output_o(cycle_tick_output_o),
  .tx_cycle_start_req_o(tx_cycle_start_req_o),
  .tx_cycle_time_o(tx_cycle_time_o),
  .tx_cycle_start_sent_i(tx_cycle_start_sent_i));

// [sim/ictm_partner.sv]
`timescale 1ns/1ps
// ====
// transmitter and receiver stand-in
module ictm_partner (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] dly_i,
  input wire logic req_i,
  input wire logic [31:0] time_i,
  input wire logic rx_go_i,
  input wire logic [31:0] rx_val_i,
  output logic sent_o,
  output logic isoch_end_o,
  output logic [31:0] sent_time_o,
  output logic rx_start_o,
  output logic [31:0] rx_time_o
);
  logic [4:0] cnt_r;
  // outside a packet the word is junk, never the last value
  assign rx_start_o = rx_go_i;
  assign rx_time_o = rx_go_i ? rx_val_i : ~rx_val_i;
  always @(negedge core_clk_i) begin
    sent_o <= 1'b0;
    isoch_end_o <= 1'b0;
    if (rst_i) begin
      cnt_r <= 5'h00;
      sent_time_o <= 32'h0000_0000;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r + 5'h01;
      if (cnt_r == {1'b0, dly_i}) begin
        sent_o <= 1'b1;
        sent_time_o <= time_i;
      end
      if (cnt_r == {1'b0, dly_i} + 5'h03) begin
        isoch_end_o <= 1'b1;
        cnt_r <= 5'h00;
      end
    end else if (req_i) begin
      cnt_r <= 5'h01;
    end
  end
endmodule // ictm_partner

// [sim/tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
  import ictm_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n = 1'b1, wr_n = 1'b1, csr_req = 1'b0, csr_wr = 1'b0;
  logic sync = 1'b0, rx_go = 1'b0, ack_n, csr_ack, tick, req, sent, iso;
  logic rx_start;
  logic [7:0] addr = 8'h00;
  logic [11:0] csr_addr = 12'h000;
  logic [3:0] dly = 4'h2;
  logic [31:0] wdata = 32'h0, csr_wdata = 32'h0, rx_val = 32'h0, q, t;
  logic [31:0] hdo, csr_rdata, txt, rx_time, sent_time;
  int err_total = 0, total_checks = 0, cyc = 0;
  ictm_top dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .host_cs_n_i(cs_n),
    .host_wr_n_i(wr_n), .host_addr_i(addr), .host_data_i(wdata),
    .host_data_o(hdo), .host_ack_n_o(ack_n), .csr_req_i(csr_req),
    .csr_wr_i(csr_wr), .csr_addr_i(csr_addr), .csr_wdata_i(csr_wdata),
    .csr_rdata_o(csr_rdata), .csr_ack_o(csr_ack), .cycle_sync_input_i(sync),
    .cycle_tick_output_o(tick), .rx_cycle_start_i(rx_start),
    .rx_cycle_time_i(rx_time), .tx_cycle_start_req_o(req),
    .tx_cycle_time_o(txt), .tx_cycle_start_sent_i(sent), .isoch_end_i(iso));
  ictm_partner u_far (.core_clk_i(core_clk_i), .rst_i(rst_i), .dly_i(dly),
    .req_i(req), .time_i(txt), .rx_go_i(rx_go), .rx_val_i(rx_val),
    .sent_o(sent), .isoch_end_o(iso), .sent_time_o(sent_time),
    .rx_start_o(rx_start), .rx_time_o(rx_time));
  initial forever #12.5 core_clk_i = ~core_clk_i;
  // ====
  // bus tasks
  task automatic host(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(negedge core_clk_i);
    cs_n = 1'b0;
    wr_n = ~w;
    addr = a;
    wdata = d;
    for (n = 0; n < 20 && ack_n !== 1'b0; n++) @(negedge core_clk_i);
    `CHK(ack_n, 1'b0)
    r = hdo;
    @(negedge core_clk_i);
    cs_n = 1'b1;
    for (n = 0; n < 20 && ack_n !== 1'b1; n++) @(negedge core_clk_i);
  endtask
  task automatic csr(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] r);
    @(negedge core_clk_i);
    csr_req = 1'b1;
    csr_wr = w;
    csr_addr = a;
    csr_wdata = d;
    @(negedge core_clk_i);
    csr_req = 1'b0;
    `CHK(csr_ack, 1'b1)
    r = csr_rdata;
  endtask
  task automatic wait_tick(output logic [31:0] r);
    for (int n = 0; n < 300 && tick !== 1'b1; n++) @(negedge core_clk_i);
    `CHK(tick, 1'b1)
    r = txt;
  endtask
  // ====
  // scenarios
  task automatic t_reset();
    logic [7:0] a [5] = '{ADDR_LINK_CTRL, ADDR_EVENT_FLAGS, ADDR_EVENT_MASK,
      ADDR_CYCLE_TIME, 8'h18};
    logic [31:0] e [5] = '{CTRL_RST, FLAGS_RST, MASK_RST, TIME_RST, 32'h0};
    for (int i = 0; i < 5; i++) begin
      host(1'b0, a[i], 32'h0, q);
      `CHK(q, e[i])
    end
    host(1'b1, 8'h10, 32'hffff_ffff, q);
    host(1'b0, 8'h10, 32'h0, q);
    `CHK(q, 32'h0000_0340)
  endtask
  task automatic t_time_rw();
    host(1'b1, 8'h14, 32'h1234_5678, q);
    csr(1'b0, 12'h200, 32'h0, q);
    `CHK(q, 32'h1234_5678)
    csr(1'b1, 12'h200, 32'h0abc_0123, q);
    host(1'b0, 8'h14, 32'h0, q);
    `CHK(q, 32'h0abc_0123)
    csr(1'b0, 12'h204, 32'h0, q);
    `CHK(q, 32'h0)
    host(1'b1, 8'h08, 32'h0000_0800, q);
    host(1'b0, 8'h08, 32'h0, q);
    `CHK(q, 32'h0000_0800)
  endtask
  task automatic t_internal();
    host(1'b1, 8'h08, 32'h0, q);
    host(1'b1, 8'h14, 32'hfff3_fbf0, q);
    host(1'b1, 8'h08, 32'h0000_0200, q);
    wait_tick(t);
    `CHK(t, 32'h0)
    host(1'b1, 8'h08, 32'h0, q);
    t = txt;
    repeat (40) @(negedge core_clk_i);
    `CHK(txt, t)
  endtask
  task automatic t_external();
    host(1'b1, 8'h14, 32'h0000_5100, q);
    host(1'b1, 8'h0c, 32'hffff_ffff, q);
    // external source only together with master mode
    host(1'b1, 8'h08, 32'h0000_0e00, q);
    sync = 1'b1;
    wait_tick(t);
    `CHK(t[24:12], 13'd6)
    `CHK(t[11:0], 12'h000)
    sync = 1'b0;
    repeat (30) @(negedge core_clk_i);
    `CHK(sent_time[24:12], 13'd6)
    host(1'b0, 8'h0c, 32'h0, q);
    `CHK(q, 32'h0000_0300)
    host(1'b1, 8'h08, 32'h0, q);
  endtask
  task automatic t_slave();
    host(1'b1, 8'h08, 32'h0000_0200, q);
    host(1'b1, 8'h0c, 32'hffff_ffff, q);
    @(negedge core_clk_i);
    rx_val = 32'h0606_4010;
    rx_go = 1'b1;
    @(negedge core_clk_i);
    rx_go = 1'b0;
    `CHK(txt[31:12], 20'h06064)
    host(1'b0, 8'h0c, 32'h0, q);
    `CHK(q, 32'h0000_0200)
    host(1'b1, 8'h0c, 32'hffff_ffff, q);
    // loss needs two full offset wraps, 5000 core cycles each
    repeat (10100) @(negedge core_clk_i);
    host(1'b0, 8'h0c, 32'h0, q);
    `CHK(q, 32'h0000_0040)
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    // reset kept well past the two-cycle minimum
    repeat (12) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_time_rw();
    t_internal();
    t_external();
    t_slave();
    final_report();
  end
endmodule // tb
